/* include/slpa_pkg.sv */
package slpa_pkg;
   // Port count and per-port field layout
   localparam int NUM_PORTS = 4;

   // Register byte offsets on APB
   localparam logic [11:0] OFF_PORT_CTRL   = 12'h000;
   localparam logic [11:0] OFF_PORT_STATUS = 12'h004;
   localparam logic [11:0] OFF_PWR_CTRL    = 12'h008;
   localparam logic [11:0] OFF_PWR_STATUS  = 12'h00C;
   localparam logic [11:0] OFF_WAKE_CMD    = 12'h010;

   // Field positions in port control: enables at [3:0], gating at [11:8], devsleep req [19:16]
   localparam int FLD_EN_LSB    = 0;
   localparam int FLD_GATE_LSB  = 8;
   localparam int FLD_DSLP_LSB  = 16;
   // Power control: bit 0 = D3 state, bit 1 = low power option
   localparam int FLD_D3        = 0;
   localparam int FLD_LOWPWR    = 1;

   // Reset values
   localparam logic [31:0] RST_PORT_CTRL = 32'h0000_000F;
   localparam logic [31:0] RST_PWR_CTRL  = 32'h0000_0000;

   // Timing: wake budgets
   localparam int CLK_MHZ          = 125;
   localparam int PARTIAL_EXIT_NS  = 10;
   localparam int SLUMBER_EXIT_MS  = 10;
   localparam int DEVSLP_EXIT_MS   = 20;
   localparam int PARTIAL_EXIT_CYC = (PARTIAL_EXIT_NS * CLK_MHZ) / 1000;
   localparam int SLUMBER_EXIT_CYC = SLUMBER_EXIT_MS * 1000 * CLK_MHZ;
   localparam int DEVSLP_EXIT_CYC  = DEVSLP_EXIT_MS * 1000 * CLK_MHZ;

   // Link power states, one-hot
   typedef enum logic [4:0] {
      SLPA_ACTIVE  = 5'h01,
      SLPA_PARTIAL = 5'h02,
      SLPA_SLUMBER = 5'h04,
      SLPA_DEVSLP  = 5'h08,
      SLPA_WAKING  = 5'h10
   } slpa_link_t;

   // Link request from the drive
   typedef struct packed {
      logic req_partial;
      logic req_slumber;
      logic comwake;
   } slpa_link_in_t;

   // Link answers toward the drive
   typedef struct packed {
      logic pm_ack;
      logic comwake;
      logic devslp;
   } slpa_link_out_t;
endpackage : slpa_pkg

/* core/slpa_led.sv */
`timescale 1ns/1ps
module slpa_led (
   // Clock and reset
   input  wire logic                           core_clk_in,
   input  wire logic                           resetn_in,
   input  wire logic                           clk_en_in,
   // Busy bits
   input  wire logic [slpa_pkg::NUM_PORTS-1:0] busy_in,
   // Open-drain pin
   output logic                                activity_led_n_out,
   output logic                                activity_led_n_oe_out
);
   logic led_on;

   // Registered OR so decode hazards never flash the LED
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         led_on <= 1'b0;
      end else if (clk_en_in) begin
         led_on <= |busy_in;
      end
   end

   // Only ever drive low; released pin floats to the pull-up
   assign activity_led_n_out    = 1'b0;
   assign activity_led_n_oe_out = led_on;

   a_led_follows_busy: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      clk_en_in |=> activity_led_n_oe_out == $past(|busy_in))
      else $error("LED enable does not follow busy OR");
   a_led_never_high: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      activity_led_n_out == 1'b0)
      else $error("LED pin driven high");
   c_led_on: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
      activity_led_n_oe_out);
endmodule : slpa_led

/* core/slpa_port_link.sv */
`timescale 1ns/1ps
module slpa_port_link (
   // Clock and reset
   input  wire logic                    core_clk_in,
   input  wire logic                    resetn_in,
   input  wire logic                    clk_en_in,
   // Controls
   input  wire logic                    port_enable_bit_in,
   input  wire logic                    d3_in,
   input  wire logic                    low_power_in,
   input  wire logic                    devslp_req_in,
   input  wire logic                    need_link_in,
   input  wire logic                    attached_in,
   // Link
   input  wire slpa_pkg::slpa_link_in_t link_in,
   output slpa_pkg::slpa_link_out_t     link_out,
   // Status
   output slpa_pkg::slpa_link_t         state_out,
   output logic                         present_out,
   output logic                         wake_missed_out
);
   slpa_pkg::slpa_link_t state;
   slpa_pkg::slpa_link_t next_state;
   logic                 deaf;

   // Low-power option shuts OOB detect in Slumber, so drive wakes are lost
   assign deaf = low_power_in && (state == slpa_pkg::SLPA_SLUMBER);

   // Drive requests are taken, never issued by us
   always_comb begin
      next_state = state;
      case (state)
         slpa_pkg::SLPA_ACTIVE: begin
            if (link_in.req_partial) next_state = slpa_pkg::SLPA_PARTIAL;
            else if (link_in.req_slumber) next_state = slpa_pkg::SLPA_SLUMBER;
         end
         slpa_pkg::SLPA_PARTIAL: begin
            if (need_link_in || link_in.comwake) next_state = slpa_pkg::SLPA_WAKING;
         end
         slpa_pkg::SLPA_SLUMBER: begin
            if (devslp_req_in) next_state = slpa_pkg::SLPA_DEVSLP;
            else if (need_link_in || (link_in.comwake && !deaf))
               next_state = slpa_pkg::SLPA_WAKING;
         end
         slpa_pkg::SLPA_DEVSLP: begin
            // Dropped DevSleep request or a host wake brings the link back to Slumber
            if (!devslp_req_in || need_link_in) next_state = slpa_pkg::SLPA_SLUMBER;
         end
         slpa_pkg::SLPA_WAKING: next_state = slpa_pkg::SLPA_ACTIVE;
         default: next_state = slpa_pkg::SLPA_ACTIVE;
      endcase
   end

   // Link state register
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         state <= slpa_pkg::SLPA_ACTIVE;
      end else if (clk_en_in) begin
         state <= next_state;
      end
   end

   // Outputs: ack drive requests taken in Active, COMWAKE while waking on a host wake
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         link_out        <= '0;
         wake_missed_out <= 1'b0;
      end else if (clk_en_in) begin
         link_out.pm_ack  <= (link_in.req_partial || link_in.req_slumber)
                             && state == slpa_pkg::SLPA_ACTIVE;
         link_out.comwake <= next_state == slpa_pkg::SLPA_WAKING && need_link_in;
         link_out.devslp  <= next_state == slpa_pkg::SLPA_DEVSLP;
         wake_missed_out  <= wake_missed_out || (deaf && link_in.comwake);
      end
   end

   // In D3 or disabled, the port reads empty
   assign present_out = attached_in && port_enable_bit_in && !d3_in;
   assign state_out   = state;

   a_ack_request: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      clk_en_in && state == slpa_pkg::SLPA_ACTIVE && link_in.req_slumber |=> link_out.pm_ack)
      else $error("Drive PM request not acknowledged");
   a_devslp_from_slumber: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      clk_en_in && next_state == slpa_pkg::SLPA_DEVSLP |->
      state inside {slpa_pkg::SLPA_SLUMBER, slpa_pkg::SLPA_DEVSLP})
      else $error("DevSleep entered outside Slumber");
   a_wake_one_cycle: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      clk_en_in && state == slpa_pkg::SLPA_WAKING |=> state == slpa_pkg::SLPA_ACTIVE)
      else $error("Wake did not finish in budget");
   a_no_host_entry: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      clk_en_in && state == slpa_pkg::SLPA_ACTIVE && !link_in.req_partial
      && !link_in.req_slumber |=> state == slpa_pkg::SLPA_ACTIVE)
      else $error("Host initiated a low power entry");
   a_wake_on_need: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      clk_en_in && state == slpa_pkg::SLPA_PARTIAL && need_link_in |=> link_out.comwake)
      else $error("No COMWAKE before cable use");
   c_slumber_wake: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
      state == slpa_pkg::SLPA_SLUMBER ##1 state == slpa_pkg::SLPA_WAKING);
   c_devslp: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
      state == slpa_pkg::SLPA_DEVSLP);
endmodule : slpa_port_link

/* core/slpa_top.sv */
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Contract
// - Accept drive PM entries, never initiate them
// - Acknowledge every drive PM request; the code acks only requests made while the link is Active
// - Send COMWAKE before using a sleeping link
// - Partial exit 10 ns, Slumber 10 ms
// - DevSleep exit within 20 ms
// - DevSleep asserted only from Slumber
// - D3 blocks all but config accesses
// - No interrupts while in D3
// - Pending interrupt may fire after D3
// - D3 ports read as empty, low power
// - Leaving D3 does no internal reset
// - Low power option may miss drive wake
// - Per-port PHY dynamic gating enable
// - Presence bit shows drive attached
// - LED active when any port busy
// - LED is active-low open drain
module slpa_top (
   // Clock, reset, enable
   input  wire logic                                 core_clk_in,
   input  wire logic                                 resetn_in,
   input  wire logic                                 clk_en_in,
   // APB slave
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [11:0]                          paddr,
   input  wire logic [31:0]                          pwdata,
   output logic                                      pready,
   output logic [31:0]                               prdata,
   output logic                                      pslverr,
   // Access space qualifier: high for configuration space
   input  wire logic                                 cfg_space_in,
   // Core side per port
   input  wire logic [slpa_pkg::NUM_PORTS-1:0]       busy_in,
   input  wire logic [slpa_pkg::NUM_PORTS-1:0]       attached_in,
   input  wire logic [slpa_pkg::NUM_PORTS-1:0]       irq_pending_in,
   // Links
   input  wire slpa_pkg::slpa_link_in_t [slpa_pkg::NUM_PORTS-1:0] link_in,
   output slpa_pkg::slpa_link_out_t [slpa_pkg::NUM_PORTS-1:0]     link_out,
   // PHY gating and interrupt
   output logic [slpa_pkg::NUM_PORTS-1:0]            phy_dynamic_gating_enable_out,
   output logic                                      irq_out,
   // Activity LED pin
   output logic                                      activity_led_n_out,
   output logic                                      activity_led_n_oe_out
);
   localparam int NP = slpa_pkg::NUM_PORTS;

   logic [31:0]                   port_control_status;
   logic [31:0]                   pwr_ctrl;
   logic [NP-1:0]                 wake_req;
   logic [NP-1:0]                 present;
   logic [NP-1:0]                 missed;
   slpa_pkg::slpa_link_t [NP-1:0] lstate;
   logic                          d3;
   logic                          next_d3;
   logic                          access;
   logic                          blocked;

   // Register selection shared by read and write paths
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   assign d3      = pwr_ctrl[slpa_pkg::FLD_D3];
   assign access  = psel && penable;
   // In D3 only config space gets through; others abort as error
   assign blocked = d3 && !cfg_space_in;
   // Zero wait states keeps the slave simple
   assign pready  = 1'b1;
   // D3 value after this edge, so the interrupt is masked from the first D3 cycle on
   assign next_d3 = (access && pwrite && cfg_space_in && hit(paddr, slpa_pkg::OFF_PWR_CTRL))
                    ? pwdata[slpa_pkg::FLD_D3] : d3;

   // Port control and power control writes; nothing cleared on D3 exit
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         port_control_status <= slpa_pkg::RST_PORT_CTRL;
         pwr_ctrl            <= slpa_pkg::RST_PWR_CTRL;
      end else if (clk_en_in && access && pwrite) begin
         if (hit(paddr, slpa_pkg::OFF_PORT_CTRL) && !blocked)
            port_control_status <= pwdata;
         if (hit(paddr, slpa_pkg::OFF_PWR_CTRL) && cfg_space_in)
            pwr_ctrl <= pwdata;
      end
   end

   // Wake command: one-cycle request per port, written bit starts COMWAKE on a port in Partial or Slumber
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         wake_req <= '0;
      end else if (clk_en_in) begin
         wake_req <= (access && pwrite && !blocked && hit(paddr, slpa_pkg::OFF_WAKE_CMD))
                     ? pwdata[NP-1:0] : '0;
      end
   end

   // Read data, zero for unmapped or D3-blocked reads
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en_in && psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (!(d3 && !cfg_space_in)) begin
            if (hit(paddr, slpa_pkg::OFF_PORT_CTRL))   prdata <= port_control_status;
            if (hit(paddr, slpa_pkg::OFF_PORT_STATUS))
               prdata <= {20'h00000, missed, 4'h0, present};
            if (hit(paddr, slpa_pkg::OFF_PWR_CTRL))    prdata <= pwr_ctrl;
            if (hit(paddr, slpa_pkg::OFF_PWR_STATUS))
               prdata <= {27'h0000000, lstate[0]};
         end
      end
   end

   // Unmapped or D3-blocked accesses answer with an error
   always_comb begin
      pslverr = 1'b0;
      if (access) begin
         pslverr = blocked || !(hit(paddr, slpa_pkg::OFF_PORT_CTRL)
                   || hit(paddr, slpa_pkg::OFF_PORT_STATUS)
                   || hit(paddr, slpa_pkg::OFF_PWR_CTRL)
                   || hit(paddr, slpa_pkg::OFF_PWR_STATUS)
                   || hit(paddr, slpa_pkg::OFF_WAKE_CMD));
      end
   end

   // Interrupt masked in D3; pending status raises it again after D0
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         irq_out <= 1'b0;
      end else if (clk_en_in) begin
         irq_out <= |irq_pending_in && !next_d3;
      end
   end

   // Per-port link engines and gating enables
   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_port
         slpa_port_link slpa_port_link_inst (
            .core_clk_in        (core_clk_in),
            .resetn_in          (resetn_in),
            .clk_en_in          (clk_en_in),
            .port_enable_bit_in (port_control_status[slpa_pkg::FLD_EN_LSB + g]),
            .d3_in              (d3),
            .low_power_in       (pwr_ctrl[slpa_pkg::FLD_LOWPWR]),
            .devslp_req_in      (port_control_status[slpa_pkg::FLD_DSLP_LSB + g]),
            .need_link_in       (wake_req[g]),
            .attached_in        (attached_in[g]),
            .link_in            (link_in[g]),
            .link_out           (link_out[g]),
            .state_out          (lstate[g]),
            .present_out        (present[g]),
            .wake_missed_out    (missed[g])
         );
         // D3 forces gating on to save power
         assign phy_dynamic_gating_enable_out[g] =
            port_control_status[slpa_pkg::FLD_GATE_LSB + g] || d3;
      end
   endgenerate

   // Activity LED
   slpa_led slpa_led_inst (
      .core_clk_in           (core_clk_in),
      .resetn_in             (resetn_in),
      .clk_en_in             (clk_en_in),
      .busy_in               (busy_in),
      .activity_led_n_out    (activity_led_n_out),
      .activity_led_n_oe_out (activity_led_n_oe_out)
   );

   a_d3_no_irq: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      d3 |-> !irq_out)
      else $error("Interrupt raised in D3");
   a_d3_abort_mem: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      access && d3 && !cfg_space_in |-> pslverr)
      else $error("Memory access in D3 not aborted");
   a_d3_no_present: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      d3 |-> present == '0)
      else $error("Port present in D3");
   a_d3_exit_keep: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      $fell(d3) |-> $stable(port_control_status))
      else $error("Port control lost on D3 exit");
   a_irq_after_d3: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      clk_en_in && !d3 && |irq_pending_in ##1 !d3 |-> irq_out)
      else $error("Pending interrupt not raised in D0");
   c_d3_entry: cover property (@(posedge core_clk_in) disable iff (!resetn_in) $rose(d3));
   c_wake_cmd: cover property (@(posedge core_clk_in) disable iff (!resetn_in) |wake_req);
endmodule : slpa_top

/* tb/slpa_drive_model.sv */
`timescale 1ns/1ps
// Behavioural drive on every port: raises link power requests and out-of-band wakes
module slpa_drive_model (
   // Clock
   input  wire logic                                               core_clk_in,
   // Link answers from the host
   input  wire slpa_pkg::slpa_link_out_t [slpa_pkg::NUM_PORTS-1:0] host_link_in,
   // Commands outstanding per port
   input  wire logic [slpa_pkg::NUM_PORTS-1:0]                     cmds_outstanding_in,
   // Link toward the host
   output slpa_pkg::slpa_link_in_t [slpa_pkg::NUM_PORTS-1:0]       drive_link_out
);
   int                             ack_count  = 0;
   int                             wake_count = 0;
   int                             dslp_exit_count = 0;
   logic [slpa_pkg::NUM_PORTS-1:0] in_devslp  = '0;

   // Quiet link at time zero
   initial drive_link_out = '0;

   // Count host pulses; a dropped sleep level puts the drive back in Slumber
   always @(posedge core_clk_in) begin
      for (int p = 0; p < slpa_pkg::NUM_PORTS; p++) begin
         if (host_link_in[p].pm_ack === 1'b1) ack_count++;
         if (host_link_in[p].comwake === 1'b1) wake_count++;
         // Falling sleep level: the drive leaves DevSleep back to Slumber
         if (in_devslp[p] && host_link_in[p].devslp === 1'b0) dslp_exit_count++;
         in_devslp[p] <= host_link_in[p].devslp;
      end
   end

   // One-cycle power request, Slumber or Partial
   task automatic pm_request(input int p, input bit slumber);
      @(posedge core_clk_in);
      drive_link_out[p].req_partial <= !slumber;
      drive_link_out[p].req_slumber <= slumber;
      @(posedge core_clk_in);
      drive_link_out[p].req_partial <= 1'b0;
      drive_link_out[p].req_slumber <= 1'b0;
   endtask : pm_request

   // Drive-side wake; this drive has no reset signal, so only COMWAKE exists
   task automatic wake(input int p);
      // Look after the edge, so a busy level set at the same edge is seen
      @(posedge core_clk_in);
      if (cmds_outstanding_in[p] !== 1'b1) return;
      drive_link_out[p].comwake <= 1'b1;
      @(posedge core_clk_in);
      drive_link_out[p].comwake <= 1'b0;
   endtask : wake
endmodule : slpa_drive_model

/* tb/slpa_top_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the link power and activity block
module slpa_top_test;
   logic                             core_clk_in = 1'b0;
   logic                             resetn_in   = 1'b0;
   logic                             clk_en_in   = 1'b1;
   logic                             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]                      paddr  = 12'h000;
   logic [31:0]                      pwdata = 32'h0000_0000;
   logic                             cfg_space_in = 1'b0;
   logic [3:0]                       busy_in = 4'h0, attached_in = 4'h0, irq_pending_in = 4'h0;
   logic                             pready, pslverr, irq_out, led_n, led_oe, err;
   logic [31:0]                      prdata, rd;
   logic [3:0]                       gate;
   slpa_pkg::slpa_link_in_t  [3:0]   link_in;
   slpa_pkg::slpa_link_out_t [3:0]   link_out;
   int                               bad_count = 0, comparisons = 0;
   // External pull-up holds the pin high while undriven
   wire                              led_pin = led_oe ? led_n : 1'b1;

   // 125 MHz clock
   always #4 core_clk_in = ~core_clk_in;

   slpa_top slpa_top_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
      .clk_en_in(clk_en_in),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .cfg_space_in(cfg_space_in),
      .busy_in(busy_in), .attached_in(attached_in), .irq_pending_in(irq_pending_in),
      .link_in(link_in), .link_out(link_out), .phy_dynamic_gating_enable_out(gate),
      .irq_out(irq_out), .activity_led_n_out(led_n), .activity_led_n_oe_out(led_oe));

   slpa_drive_model slpa_drive_model_inst (.core_clk_in(core_clk_in), .host_link_in(link_out),
      .cmds_outstanding_in(busy_in), .drive_link_out(link_in));

   // Verdict and end of run
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   // Compare one value against its expectation
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
         bad_count++;
      end
   endtask : check

   // APB transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_in);
      penable <= 1'b1;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         bad_count++;
         stop_test();
      end
   endtask : apb

   // Let a few edges pass
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask : idle

   // Watchdog against a hung run
   initial begin
      #400000;
      bad_count++;
      stop_test();
   end

   // Main sequence
   initial begin
      idle(4);
      resetn_in <= 1'b1;
      apb(1'b0, slpa_pkg::OFF_PORT_CTRL, 32'h0);
      check(rd, slpa_pkg::RST_PORT_CTRL);
      apb(1'b0, slpa_pkg::OFF_PWR_CTRL, 32'h0);
      check(rd, slpa_pkg::RST_PWR_CTRL);
      apb(1'b0, slpa_pkg::OFF_PWR_STATUS, 32'h0);
      check(rd, 32'h0000_0001);
      apb(1'b0, 12'h020, 32'h0);
      check({31'h0, err}, 32'h1);
      // Presence follows attach and port enable; software re-enables to poll
      attached_in <= 4'b0101;
      apb(1'b0, slpa_pkg::OFF_PORT_STATUS, 32'h0);
      check(rd & 32'hF, 32'h5);
      apb(1'b1, slpa_pkg::OFF_PORT_CTRL, 32'h0000_000E);
      apb(1'b0, slpa_pkg::OFF_PORT_STATUS, 32'h0);
      check(rd & 32'hF, 32'h4);
      apb(1'b1, slpa_pkg::OFF_PORT_CTRL, 32'h0000_0A0F);
      apb(1'b0, slpa_pkg::OFF_PORT_STATUS, 32'h0);
      check(rd & 32'hF, 32'h5);
      check({28'h0, gate}, 32'hA);
      // Activity pin pulled low only while a port is busy
      busy_in <= 4'b0100;
      idle(3);
      check({31'h0, led_pin}, 32'h0);
      busy_in <= 4'b0000;
      idle(3);
      check({30'h0, led_oe, led_pin}, 32'h1);
      // Clock enable low freezes the LED register against new busy levels
      clk_en_in <= 1'b0;
      busy_in <= 4'b0100;
      idle(3);
      check({31'h0, led_oe}, 32'h0);
      clk_en_in <= 1'b1;
      busy_in <= 4'b0000;
      idle(2);
      // Partial entry acked, host wake returns to active
      slpa_drive_model_inst.pm_request(0, 1'b0);
      idle(2);
      check(32'(slpa_drive_model_inst.ack_count), 32'h1);
      apb(1'b0, slpa_pkg::OFF_PWR_STATUS, 32'h0);
      check(rd, 32'h0000_0002);
      apb(1'b1, slpa_pkg::OFF_WAKE_CMD, 32'h0000_0001);
      idle(3);
      check(32'(slpa_drive_model_inst.wake_count), 32'h1);
      apb(1'b0, slpa_pkg::OFF_PWR_STATUS, 32'h0);
      check(rd, 32'h0000_0001);
      // Sleep request ignored while active, taken in Slumber
      apb(1'b1, slpa_pkg::OFF_PORT_CTRL, 32'h0001_0A0F);
      idle(2);
      check({31'h0, link_out[0].devslp}, 32'h0);
      slpa_drive_model_inst.pm_request(0, 1'b1);
      idle(3);
      check(32'(slpa_drive_model_inst.ack_count), 32'h2);
      check({31'h0, link_out[0].devslp}, 32'h1);
      apb(1'b0, slpa_pkg::OFF_PWR_STATUS, 32'h0);
      check(rd, 32'h0000_0008);
      apb(1'b1, slpa_pkg::OFF_PORT_CTRL, 32'h0000_0A0F);
      idle(2);
      apb(1'b0, slpa_pkg::OFF_PWR_STATUS, 32'h0);
      check(rd, 32'h0000_0004);
      check(32'(slpa_drive_model_inst.dslp_exit_count), 32'h1);
      // Low-power option loses a drive wake, recorded as missed
      cfg_space_in <= 1'b1;
      apb(1'b1, slpa_pkg::OFF_PWR_CTRL, 32'h0000_0002);
      busy_in <= 4'b0001;
      slpa_drive_model_inst.wake(0);
      idle(2);
      apb(1'b0, slpa_pkg::OFF_PORT_STATUS, 32'h0);
      check(rd & 32'h100, 32'h100);
      apb(1'b1, slpa_pkg::OFF_PWR_CTRL, 32'h0000_0000);
      slpa_drive_model_inst.wake(0);
      idle(3);
      apb(1'b0, slpa_pkg::OFF_PWR_STATUS, 32'h0);
      check(rd, 32'h0000_0001);
      // D3: interrupt held back, memory space refused, ports empty
      busy_in <= 4'b0000;
      irq_pending_in <= 4'b0010;
      apb(1'b1, slpa_pkg::OFF_PWR_CTRL, 32'h0000_0001);
      idle(2);
      check({31'h0, irq_out}, 32'h0);
      check({28'h0, gate}, 32'hF);
      apb(1'b0, slpa_pkg::OFF_PORT_STATUS, 32'h0);
      check(rd & 32'hF, 32'h0);
      cfg_space_in <= 1'b0;
      apb(1'b1, slpa_pkg::OFF_PORT_CTRL, 32'h0000_0000);
      check({31'h0, err}, 32'h1);
      apb(1'b0, slpa_pkg::OFF_PORT_CTRL, 32'h0);
      check({err, rd[30:0]}, 32'h8000_0000);
      cfg_space_in <= 1'b1;
      apb(1'b1, slpa_pkg::OFF_PWR_CTRL, 32'h0000_0000);
      cfg_space_in <= 1'b0;
      idle(2);
      check({31'h0, irq_out}, 32'h1);
      apb(1'b0, slpa_pkg::OFF_PORT_CTRL, 32'h0);
      check(rd, 32'h0000_0A0F);
      stop_test();
   end
endmodule : slpa_top_test
